/* hdl/swp_defines.svh */
// constants of the sleep, wake and program entry block
`ifndef SWP_DEFINES_SVH
`define SWP_DEFINES_SVH
`define SWP_ADDR_CTRL 4'h0
`define SWP_ADDR_STATUS 4'h4
`define SWP_ADDR_IRQ 4'h8
`define SWP_ADDR_PROG 4'hC
`define SWP_BIT_PD 3
`define SWP_BIT_TO 4
`define SWP_BIT_GIE 7
`define SWP_IRQ_RESET 8'h00
`define SWP_VECTOR 13'h0004
`define SWP_ID_FIRST 14'h2000
`define SWP_ID_LAST 14'h2003
`define SWP_ID_MASK 14'h000F
`define SWP_CMD_BITS 6
`define SWP_DATA_BITS 14
`define SWP_RESP_OKAY 2'h0
`define SWP_RESP_SLVERR 2'h2
`endif

/* hdl/swp_pkg.sv */
// types of the sleep, wake and program entry block
package swp_pkg;
   typedef enum logic [1:0] {
      SWP_RUN = 2'b00,
      SWP_SLEEP = 2'b01,
      SWP_WAKE = 2'b10,
      SWP_PROG = 2'b11
   } swp_state_type;
endpackage

/* hdl/swp_sleep_wake.sv */
// sleep, wake and program entry control with AXI4-Lite register access
//
// Functional notes
// RULE1 - sleep instruction enters power-down
// RULE2 - entry clears watchdog, clears pd, sets to
// RULE3 - ports hold their drive during power-down
// RULE4 - watchdog reset never drives master clear
// RULE5 - wake on reset, watchdog, enabled interrupts
// RULE6 - clocked peripheral interrupts blocked while asleep
// RULE7 - master clear resets; others resume execution
// RULE8 - pd set at power-up, cleared by sleep
// RULE9 - watchdog wake clears the to flag
// RULE10 - next instruction prefetched during sleep
// RULE11 - individual enable gates wake, not global
// RULE12 - global enable set: next instruction, then vector
// RULE13 - pending enabled flag makes sleep a nop
// RULE14 - interrupt during sleep: complete, then wake
// RULE15 - id words only in program mode, low nibble
// RULE16 - programmer holds clock, data low on entry
// RULE17 - program clock and data pins as inputs
// RULE18 - pc zero; 6-bit command then 14 data bits
// RULE19 - verify reads only without code protection
// RULE20 - mask rom variant programs data eeprom only
// RULE21 - global enable at bit 7, cleared on reset
// RULE22 - watchdog disabled by config gives no wake
// RULE23 - stall core while asleep, resume on wake
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "swp_defines.svh"
module swp_sleep_wake #(
   parameter int WDT_LIMIT = 1800,
   parameter bit MASK_ROM = 1'b0
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_op,
   input wire logic watchdog_clear_op,
   input wire logic [12:0] next_pc,
   input wire logic watchdog_enable_cfg,
   input wire logic code_protect_cfg,
   input wire logic master_clear_pin,
   input wire logic programming_high_voltage,
   input wire logic external_edge_irq_pin,
   input wire logic port_change_event,
   input wire logic eeprom_done_event,
   input wire logic timer_overflow_event,
   input wire logic prog_clock_pin,
   input wire logic prog_data_pin,
   input wire logic [13:0] prog_read_word,
   output logic prog_data_out,
   output logic prog_data_oe,
   output logic [5:0] prog_command,
   output logic [13:0] prog_word,
   output logic [13:0] prog_addr,
   output logic prog_strobe,
   output logic prog_write_allow,
   output logic prog_mode,
   output logic core_stall,
   output logic osc_enable,
   output logic port_hold,
   output logic core_reset,
   output logic watchdog_reset,
   output logic vector_request,
   output logic [12:0] fetch_addr,
   output logic [7:0] status_flags
);
   import swp_pkg::*;
   swp_state_type state;
   logic [2:0] master_clear_pin_s, hv_s, ext_s, pclk_s, pdat_s;
   logic [7:0] irq_ctl;
   logic [3:0] irq_flag;
   logic pd, to;
   logic [31:0] wdt;
   logic gie_at_wake;
   logic [4:0] bitcnt;
   logic [5:0] cmd;
   logic [13:0] shift;
   logic [13:0] pc;
   logic aw_hold, w_hold;
   logic [3:0] aw_addr;
   logic [31:0] w_data;

   // three-stage synchronisers; only stages two and three are compared
   always_ff @(posedge aclk)
   begin
      master_clear_pin_s <= {master_clear_pin_s[1:0], master_clear_pin};
      hv_s <= {hv_s[1:0], programming_high_voltage};
      ext_s <= {ext_s[1:0], external_edge_irq_pin};
      pclk_s <= {pclk_s[1:0], prog_clock_pin};
      pdat_s <= {pdat_s[1:0], prog_data_pin};
   end

   wire master_clear_pin_low = ~master_clear_pin_s[2] & ~master_clear_pin_s[1];
   wire hv_rise = hv_s[1] & ~hv_s[2];
   wire hv_now = hv_s[1] & hv_s[2];
   wire ext_rise = ext_s[1] & ~ext_s[2];
   wire pclk_rise = pclk_s[1] & ~pclk_s[2];
   wire pclk_fall = ~pclk_s[1] & pclk_s[2];
   wire pclk_low = ~pclk_s[1] & ~pclk_s[2];
   wire pdat_low = ~pdat_s[1] & ~pdat_s[2];

   // irq_ctl: 7 global, 3 eeprom, 2 port, 1 edge, 0 timer enable
   wire asleep = state == SWP_SLEEP;
   // timer runs on phase clocks, so it cannot flag while asleep [RULE6]
   wire [3:0] raw_evt = {eeprom_done_event, port_change_event, ext_rise,
      timer_overflow_event & ~asleep};
   wire [3:0] pending = irq_flag & irq_ctl[3:0];
   // wake ignores the global enable [RULE11] [RULE5]
   wire irq_wake = |pending;
   wire wdt_on = watchdog_enable_cfg; // [RULE22]
   wire wdt_expire = wdt_on && wdt >= WDT_LIMIT - 1;
   wire sleep_nop = sleep_op && irq_wake; // [RULE13]
   wire sleep_take = sleep_op && !irq_wake && state == SWP_RUN;
   // entry only on the rising voltage, with clock and data already low
   wire prog_entry = hv_rise && pclk_low && pdat_low && state != SWP_PROG;
   wire id_addr = pc >= `SWP_ID_FIRST && pc <= `SWP_ID_LAST;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= SWP_RUN;
         pd <= 1'b1; // [RULE8]
         to <= 1'b1;
         wdt <= '0;
         irq_flag <= '0;
         gie_at_wake <= 1'b0;
         core_reset <= 1'b1;
         watchdog_reset <= 1'b0;
         vector_request <= 1'b0;
         fetch_addr <= '0;
      end
      else
      begin
         irq_flag <= irq_flag | raw_evt;
         core_reset <= master_clear_pin_low;
         watchdog_reset <= 1'b0;
         vector_request <= 1'b0;
         if (sleep_take || watchdog_clear_op || !wdt_on)
            wdt <= '0; // [RULE2]
         else if (wdt_expire)
            wdt <= '0;
         else
            wdt <= wdt + 32'd1;
         if (master_clear_pin_low && state != SWP_PROG)
         begin
            state <= SWP_RUN; // full reset [RULE7]
            pd <= 1'b1;
            to <= 1'b1;
         end
         else if (prog_entry)
            state <= SWP_PROG;
         else
            case (state)
               SWP_RUN:
               begin
                  if (sleep_take)
                  begin
                     state <= SWP_SLEEP; // [RULE1]
                     pd <= 1'b0; // [RULE2] [RULE8]
                     to <= 1'b1; // [RULE2]
                     fetch_addr <= next_pc; // [RULE10]
                  end
                  else if (wdt_expire)
                  begin
                     to <= 1'b0;
                     // internal only, master clear untouched [RULE4]
                     watchdog_reset <= 1'b1;
                  end
               end
               SWP_SLEEP:
               begin
                  // late interrupt wakes after full sleep effects [RULE14]
                  if (irq_wake)
                  begin
                     state <= SWP_WAKE;
                     gie_at_wake <= irq_ctl[`SWP_BIT_GIE];
                  end
                  else if (wdt_expire)
                  begin
                     state <= SWP_WAKE; // [RULE5] [RULE7]
                     to <= 1'b0; // [RULE9]
                     gie_at_wake <= 1'b0;
                  end
               end
               SWP_WAKE:
               begin
                  // resume at prefetched word, then vector if enabled
                  state <= SWP_RUN; // [RULE23]
                  vector_request <= gie_at_wake; // [RULE12]
               end
               default:
               begin
                  if (!hv_now)
                     state <= SWP_RUN;
               end
            endcase
      end
   end

   // serial programming: 6 command bits then 14 data bits, lsb first
   always_ff @(posedge aclk)
   begin
      if (!aresetn || state != SWP_PROG)
      begin
         bitcnt <= '0;
         cmd <= '0;
         shift <= '0;
         pc <= '0; // pc starts at zero [RULE18]
         prog_strobe <= 1'b0;
         prog_data_out <= 1'b0;
         prog_data_oe <= 1'b0;
         prog_command <= '0;
         prog_word <= '0;
         prog_addr <= '0;
      end
      else
      begin
         prog_strobe <= 1'b0;
         if (pclk_rise && bitcnt < 5'(`SWP_CMD_BITS))
         begin
            cmd <= {pdat_s[2], cmd[5:1]}; // [RULE17] [RULE18]
            bitcnt <= bitcnt + 5'd1;
            if (bitcnt == 5'(`SWP_CMD_BITS - 1))
            begin
               // verify data driven only without protection [RULE19]
               prog_data_oe <= ~code_protect_cfg;
               shift <= id_addr ? prog_read_word & `SWP_ID_MASK
                  : prog_read_word; // [RULE15]
            end
         end
         else if (pclk_rise)
         begin
            shift <= {pdat_s[2], shift[13:1]};
            prog_data_out <= shift[0];
            bitcnt <= bitcnt + 5'd1;
            if (bitcnt == 5'(`SWP_CMD_BITS + `SWP_DATA_BITS - 1))
            begin
               bitcnt <= '0;
               prog_data_oe <= 1'b0;
               prog_command <= cmd;
               prog_word <= {pdat_s[2], shift[13:1]};
               prog_strobe <= 1'b1;
               // address shown with the strobe is that of this word
               prog_addr <= pc;
               pc <= pc + 14'd1;
            end
         end
         else if (pclk_fall && prog_data_oe)
            prog_data_out <= shift[0];
      end
   end

   // outputs from flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         core_stall <= 1'b0;
         osc_enable <= 1'b1;
         port_hold <= 1'b0;
         prog_mode <= 1'b0;
         prog_write_allow <= 1'b0;
         status_flags <= '0;
      end
      else
      begin
         core_stall <= asleep || state == SWP_PROG; // [RULE23]
         osc_enable <= !asleep; // [RULE2]
         port_hold <= asleep; // [RULE3]
         prog_mode <= state == SWP_PROG;
         // mask rom parts accept only data eeprom writes [RULE20]
         prog_write_allow <= state == SWP_PROG && (!MASK_ROM ||
            pc[13]);
         status_flags <= {3'h0, to, pd, 3'h0};
      end
   end

   // AXI4-Lite slave, one write and one read at a time, served independently
   wire aw_now = aw_hold | s_axi_awvalid;
   wire w_now = w_hold | s_axi_wvalid;
   wire [3:0] wr_addr = aw_hold ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_hold ? w_data : s_axi_wdata;
   wire wr_go = aw_now && w_now && !s_axi_bvalid;
   wire wr_irq = wr_go && wr_addr == `SWP_ADDR_IRQ && s_axi_wstrb[0];
   wire wr_ok = wr_addr == `SWP_ADDR_IRQ || wr_addr == `SWP_ADDR_CTRL;
   wire [31:0] rd_val = s_axi_araddr == `SWP_ADDR_STATUS ?
      {24'h0, status_flags} : s_axi_araddr == `SWP_ADDR_IRQ ?
      {20'h0, irq_flag, irq_ctl} : s_axi_araddr == `SWP_ADDR_CTRL ?
      {30'h0, state} : {18'h0, prog_word};
   wire rd_ok = s_axi_araddr <= `SWP_ADDR_PROG;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_ctl <= `SWP_IRQ_RESET; // global enable clear [RULE21]
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SWP_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `SWP_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold <= !wr_go;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold <= !wr_go;
            w_data <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `SWP_RESP_OKAY : `SWP_RESP_SLVERR;
            if (wr_irq)
               irq_ctl <= wr_data[7:0];
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? `SWP_RESP_OKAY : `SWP_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule

/* verif/swp_sleep_wake_checker.sv */
// assertions on the sleep, wake and program entry block
`timescale 1ns/1ns
module swp_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic osc_enable,
   input wire logic port_hold,
   input wire logic core_stall,
   input wire logic [7:0] status_flags,
   input wire logic watchdog_enable_cfg,
   input wire logic watchdog_reset,
   input wire logic vector_request,
   input wire logic master_clear_pin,
   input wire logic core_reset,
   input wire logic prog_strobe,
   input wire logic prog_mode,
   input wire logic prog_data_oe,
   input wire logic code_protect_cfg
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // the pin passes three sync flops, so allow a few cycles
   sequence s_master_clear_pin_low;
      !master_clear_pin [*6];
   endsequence
   sequence s_enter;
      $fell(osc_enable);
   endsequence
   a_enter_flags: assert property (s_enter |-> status_flags[4:3] == 2'b10)
      else $error("sleep entry flags wrong");
   a_asleep_hold: assert property (!osc_enable |-> port_hold && core_stall)
      else $error("ports or core not held asleep");
   a_reset_flags: assert property ($rose(aresetn) |=> status_flags[4:3] == 2'b11)
      else $error("flags after reset wrong");
   a_wdt_off: assert property (!watchdog_enable_cfg |-> !watchdog_reset)
      else $error("disabled watchdog fired");
   a_wdt_internal: assert property (watchdog_reset |-> !core_reset)
      else $error("watchdog drove master clear reset");
   a_master_clear_pin_reset: assert property (s_master_clear_pin_low |-> core_reset)
      else $error("master clear gave no reset");
   a_vec_once: assert property (vector_request |=> !vector_request && osc_enable)
      else $error("vector request not a pulse when awake");
   a_strobe_mode: assert property (prog_strobe |-> prog_mode ##1 !prog_strobe)
      else $error("program strobe outside mode");
   a_oe_guard: assert property (prog_data_oe |-> prog_mode && !code_protect_cfg)
      else $error("data pin driven when not allowed");
endmodule
bind swp_sleep_wake swp_checker i_swp_checker (.aclk, .aresetn, .osc_enable,
   .port_hold, .core_stall, .status_flags, .watchdog_enable_cfg,
   .watchdog_reset, .vector_request, .master_clear_pin, .core_reset,
   .prog_strobe, .prog_mode, .prog_data_oe, .code_protect_cfg);

/* verif/swp_programmer.sv */
// serial programmer and reset pin model
`timescale 1ns/1ns
module swp_programmer (
   input wire logic aclk,
   output logic master_clear_pin,
   output logic programming_high_voltage,
   output logic prog_clock_pin,
   output logic prog_data_drv
);
   initial
   begin
      master_clear_pin = 1'b1;
      programming_high_voltage = 1'b0;
      prog_clock_pin = 1'b0;
      prog_data_drv = 1'b0;
   end
   task automatic pin(input logic v);
      @(posedge aclk);
      master_clear_pin <= v;
   endtask
   // clock and data driven low in the same cycle as the voltage; entry is missed unless they were already low
   task automatic enter(input logic on);
      @(posedge aclk);
      prog_clock_pin <= 1'b0;
      prog_data_drv <= 1'b0;
      programming_high_voltage <= on;
      repeat (8) @(posedge aclk);
   endtask
   // command bits then data bits, lsb first; clock idles low between
   task automatic frame(input logic [19:0] bits);
      for (int i = 0; i < 20; i++)
      begin
         @(posedge aclk);
         prog_data_drv <= bits[i];
         repeat (2) @(posedge aclk);
         prog_clock_pin <= 1'b1;
         repeat (4) @(posedge aclk);
         prog_clock_pin <= 1'b0;
         @(posedge aclk);
      end
   endtask
endmodule

/* verif/swp_sleep_wake_test.sv */
// bench of the sleep, wake and program entry block
`timescale 1ns/1ns
`include "swp_defines.svh"
module swp_sleep_wake_test;
   import swp_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_op;
   logic [3:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic watchdog_enable_cfg, code_protect_cfg, master_clear_pin;
   logic programming_high_voltage, port_change_event, eeprom_done_event;
   logic timer_overflow_event, prog_clock_pin, prog_data_pin, pdrv;
   logic prog_data_out, prog_data_oe, prog_strobe, prog_mode;
   logic osc_enable, core_reset, vector_request;
   logic ext_pin, wdt_clr, core_stall, port_hold, watchdog_reset;
   logic prog_write_allow;
   logic [7:0] status_flags;
   logic [12:0] next_pc, fetch_addr;
   logic [5:0] prog_command;
   logic [13:0] prog_word, prog_addr;
   logic [19:0] b;
   logic [33:0] q_rd[$], q_pg[$];
   int error_cnt, checks_done, cyc, vec_cnt, seed;
   assign prog_data_pin = prog_data_oe ? prog_data_out : pdrv;
   swp_programmer i_swp_programmer (.aclk, .master_clear_pin,
      .programming_high_voltage, .prog_clock_pin, .prog_data_drv(pdrv));
   swp_sleep_wake #(.WDT_LIMIT(20)) i_swp_sleep_wake (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .sleep_op, .watchdog_clear_op(wdt_clr), .next_pc,
      .watchdog_enable_cfg, .code_protect_cfg, .master_clear_pin,
      .programming_high_voltage, .external_edge_irq_pin(ext_pin),
      .port_change_event, .eeprom_done_event, .timer_overflow_event,
      .prog_clock_pin, .prog_data_pin, .prog_read_word(14'h0),
      .prog_data_out, .prog_data_oe, .prog_command, .prog_word,
      .prog_addr, .prog_strobe, .prog_write_allow, .prog_mode,
      .core_stall, .osc_enable, .port_hold, .core_reset,
      .watchdog_reset, .vector_request, .fetch_addr, .status_flags);
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic finish_test;
      if (error_cnt == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [33:0] g, input logic [33:0] x);
      checks_done++;
      if (g !== x)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, g, x);
      end
   endtask
   task automatic bit_chk(input logic g, input logic x);
      chk({33'h0, g}, {33'h0, x});
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            s_axi_bready <= 1'b0;
            chk({32'h0, s_axi_bresp}, {32'h0, `SWP_RESP_OKAY});
         end
      end
      while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
   endtask
   task automatic rd(input logic [3:0] a, input logic [33:0] x);
      q_rd.push_back(x);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) s_axi_rready <= 1'b0;
      end
      while (s_axi_arvalid || s_axi_rready);
   endtask
   // sleep pulse with a fresh address of the following word
   task automatic nap;
      @(posedge aclk);
      next_pc <= 13'($random(seed));
      sleep_op <= 1'b1;
      @(posedge aclk);
      sleep_op <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask
   task automatic events(input logic t, input logic p, input logic e);
      @(posedge aclk);
      {timer_overflow_event, port_change_event, eeprom_done_event} <= {t, p, e};
      @(posedge aclk);
      {timer_overflow_event, port_change_event, eeprom_done_event} <= 3'h0;
      repeat (50) @(posedge aclk);
   endtask
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, q_rd.pop_front());
      if (prog_strobe)
         chk({prog_addr, prog_command, prog_word}, q_pg.pop_front());
      if (vector_request) vec_cnt++;
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   initial
   begin
      seed = 32'h66f7141e;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, sleep_op, watchdog_enable_cfg} = 4'h0;
      {code_protect_cfg, port_change_event, eeprom_done_event} = 3'h0;
      {timer_overflow_event, ext_pin, wdt_clr} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, next_pc} = 53'h0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SWP_ADDR_STATUS, 34'h18);
      wr(`SWP_ADDR_CTRL, 8'hFF);
      rd(`SWP_ADDR_IRQ, 34'h0);
      rd(4'hD, {`SWP_RESP_SLVERR, 32'h0});
      nap;
      bit_chk(osc_enable, 1'b0);
      bit_chk(port_hold, 1'b1);
      bit_chk(core_stall, 1'b1);
      chk({26'h0, status_flags}, 34'h10);
      rd(`SWP_ADDR_STATUS, 34'h10);
      rd(`SWP_ADDR_CTRL, {32'h0, SWP_SLEEP});
      events(1'b0, 1'b1, 1'b1);
      bit_chk(osc_enable, 1'b0);
      wr(`SWP_ADDR_IRQ, 8'h01);
      events(1'b1, 1'b0, 1'b0);
      bit_chk(osc_enable, 1'b0);
      wr(`SWP_ADDR_IRQ, 8'h88);
      repeat (10) @(posedge aclk);
      bit_chk(osc_enable, 1'b1);
      chk(34'(vec_cnt), 34'd1);
      chk({21'h0, fetch_addr}, {21'h0, next_pc});
      nap;
      bit_chk(osc_enable, 1'b1);
      rd(`SWP_ADDR_STATUS, 34'h10);
      wr(`SWP_ADDR_IRQ, 8'h00);
      watchdog_enable_cfg <= 1'b1;
      nap;
      bit_chk(osc_enable, 1'b0);
      for (int i = 0; i < 99 && !osc_enable; i++)
         @(posedge aclk);
      watchdog_enable_cfg <= 1'b0;
      bit_chk(osc_enable, 1'b1);
      rd(`SWP_ADDR_STATUS, 34'h0);
      chk(34'(vec_cnt), 34'd1);
      nap;
      wr(`SWP_ADDR_IRQ, 8'h02);
      bit_chk(osc_enable, 1'b0);
      ext_pin <= 1'b1;
      repeat (10) @(posedge aclk);
      ext_pin <= 1'b0;
      bit_chk(osc_enable, 1'b1);
      chk(34'(vec_cnt), 34'd1);
      bit_chk(watchdog_reset, 1'b0);
      nap;
      i_swp_programmer.pin(1'b0);
      repeat (8) @(posedge aclk);
      bit_chk(core_reset, 1'b1);
      i_swp_programmer.pin(1'b1);
      repeat (8) @(posedge aclk);
      code_protect_cfg <= 1'b1;
      i_swp_programmer.enter(1'b1);
      bit_chk(prog_mode, 1'b1);
      bit_chk(prog_write_allow, 1'b1);
      for (int k = 0; k < 2; k++)
      begin
         b = 20'($random(seed));
         q_pg.push_back({14'(k), b[5:0], b[19:6]});
         i_swp_programmer.frame(b);
      end
      repeat (20) @(posedge aclk);
      i_swp_programmer.enter(1'b0);
      chk(34'(q_pg.size()), 34'd0);
      finish_test();
   end
endmodule
